// ---- vcr_device.sv ----
// Capture front end control registers, sync separator and line sync output
// Overview of operation
// - 5-bit phase code, 32 steps of 11.25 degrees
// - Phase code resets to 16
// - 7-bit gain per channel, 127 full range
// - Red gain applied on 0x00 write to 0x06
// - Green gain applied on 0x00 write to 0x08
// - Blue gain applied on 0x00 write to 0x0A
// - Gain fields reset to 100 0000
// - Offset is upper byte plus LSB bit 7
// - Manual offset uses sign plus low seven bits, +-127
// - Auto offset uses 9-bit clamp target
// - One setting LSB adds one output LSB
// - Offset upper byte pending until LSB written
// - Separator rejects pulses under threshold x 200 ns
// - Separator threshold resets to 32
// - Source override bit 7, chip chooses when clear
// - Source bit 6: pin or green embedded sync
// - Polarity override bit 5, else auto-detected
// - Input polarity bit 4, 1 active high
// - Output polarity bit 3, default active high
// - Output pulse lasts duration-register pixel clocks
module vcr_device
	import vcr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	vcr_if.dev bus,
	input wire logic i_auto_offset_en,
	input wire logic i_pix_en,
	input wire logic i_fb_clk_en,
	input wire logic i_line_sync_pin,
	input wire logic i_green_embedded_sync,
	output logic [4:0] o_phase,
	output logic [6:0] o_gain_r,
	output logic [6:0] o_gain_g,
	output logic [6:0] o_gain_b,
	output logic [8:0] o_offset_r,
	output logic [8:0] o_offset_g,
	output logic [8:0] o_offset_b,
	output logic [8:0] o_clamp_target_r,
	output logic [8:0] o_clamp_target_g,
	output logic [8:0] o_clamp_target_b,
	output logic o_sep_sync,
	output logic o_src_green,
	output logic o_in_active_high,
	output logic o_line_sync
);
	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] phase_q;
	logic [6:0] gain_pend_q [3];
	logic [6:0] gain_act_q [3];
	logic [7:0] ofs_up_q [3];
	logic [7:0] ofs_lsb_q [3];
	logic [8:0] ofs_act_q [3];
	logic [7:0] thresh_q;
	logic [7:0] ctrl_q;
	logic [7:0] len_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic [7:0] gain_addr [3];
	logic [7:0] commit_addr [3];
	logic [7:0] up_addr [3];
	logic [7:0] lsb_addr [3];
	assign gain_addr = '{ADDR_GAIN_R, ADDR_GAIN_G, ADDR_GAIN_B};
	assign commit_addr = '{ADDR_GAIN_R_COMMIT, ADDR_GAIN_G_COMMIT, ADDR_GAIN_B_COMMIT};
	assign up_addr = '{ADDR_OFS_R_UP, ADDR_OFS_G_UP, ADDR_OFS_B_UP};
	assign lsb_addr = '{ADDR_OFS_R_LSB, ADDR_OFS_G_LSB, ADDR_OFS_B_LSB};

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			phase_q <= {PHASE_RESET, 3'h0};
			thresh_q <= SEP_THRESH_RESET;
			ctrl_q <= LSYNC_CTRL_RESET;
			len_q <= LSYNC_LEN_RESET;
		end else if (bus.wr) begin
			unique case (bus.addr)
				ADDR_PHASE: phase_q <= bus.wdata;
				ADDR_SEP_THRESH: thresh_q <= bus.wdata;
				ADDR_LSYNC_CTRL: ctrl_q <= bus.wdata;
				ADDR_LSYNC_LEN: len_q <= bus.wdata;
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Per-channel staged gain and offset
	// ****************************************
	for (genvar c = 0; c < 3; c++) begin : g_chan
		always_ff @(posedge i_clk) begin
			if (!i_rstn) begin
				gain_pend_q[c] <= GAIN_RESET;
				gain_act_q[c] <= GAIN_RESET;
			end else if (bus.wr) begin
				if (bus.addr == gain_addr[c]) begin
					gain_pend_q[c] <= bus.wdata[GAIN_MSB:0];
				end
				// Only an exact 0x00 commits; other values leave the old gain
				if (bus.addr == commit_addr[c] && bus.wdata == COMMIT_VALUE) begin
					gain_act_q[c] <= gain_pend_q[c];
				end
			end
		end

		always_ff @(posedge i_clk) begin
			if (!i_rstn) begin
				ofs_up_q[c] <= OFS_RESET[8:1];
				ofs_lsb_q[c] <= 8'h00;
				ofs_act_q[c] <= OFS_RESET;
			end else if (bus.wr) begin
				if (bus.addr == up_addr[c]) begin
					ofs_up_q[c] <= bus.wdata;
				end
				if (bus.addr == lsb_addr[c]) begin
					ofs_lsb_q[c] <= bus.wdata;
					ofs_act_q[c] <= {ofs_up_q[c], bus.wdata[OFS_LSB_BIT]};
				end
			end
		end
	end

	assign o_gain_r = gain_act_q[0];
	assign o_gain_g = gain_act_q[1];
	assign o_gain_b = gain_act_q[2];
	assign o_phase = phase_q[PHASE_MSB:PHASE_LSB];

	// Manual mode keeps sign in bit 8 and seven magnitude bits 6:0, clearing bit 7; auto passes all nine
	function automatic logic [8:0] ofs_map(input logic [8:0] v, input logic auto_en);
		ofs_map = auto_en ? v : {v[8], 1'b0, v[6:0]};
	endfunction
	assign o_offset_r = ofs_map(ofs_act_q[0], i_auto_offset_en);
	assign o_offset_g = ofs_map(ofs_act_q[1], i_auto_offset_en);
	assign o_offset_b = ofs_map(ofs_act_q[2], i_auto_offset_en);
	assign o_clamp_target_r = ofs_act_q[0];
	assign o_clamp_target_g = ofs_act_q[1];
	assign o_clamp_target_b = ofs_act_q[2];

	// ****************************************
	// Read path
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= bus.rd;
			if (bus.rd) begin
				unique case (bus.addr)
					ADDR_PHASE: rdata_q <= phase_q;
					ADDR_GAIN_R: rdata_q <= {1'b0, gain_pend_q[0]};
					ADDR_GAIN_G: rdata_q <= {1'b0, gain_pend_q[1]};
					ADDR_GAIN_B: rdata_q <= {1'b0, gain_pend_q[2]};
					ADDR_OFS_R_UP: rdata_q <= ofs_up_q[0];
					ADDR_OFS_R_LSB: rdata_q <= ofs_lsb_q[0];
					ADDR_OFS_G_UP: rdata_q <= ofs_up_q[1];
					ADDR_OFS_G_LSB: rdata_q <= ofs_lsb_q[1];
					ADDR_OFS_B_UP: rdata_q <= ofs_up_q[2];
					ADDR_OFS_B_LSB: rdata_q <= ofs_lsb_q[2];
					ADDR_SEP_THRESH: rdata_q <= thresh_q;
					ADDR_LSYNC_CTRL: rdata_q <= ctrl_q;
					ADDR_LSYNC_LEN: rdata_q <= len_q;
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end
	assign bus.rdata = rdata_q;
	assign bus.rvalid = rvalid_q;

	// ****************************************
	// Automatic source and polarity detection
	// ****************************************
	logic pin_prev_q, grn_prev_q;
	logic [4:0] pin_act_q, grn_act_q;
	logic [15:0] hi_cnt_q, lo_cnt_q;
	logic auto_src_q, auto_pol_q;
	logic use_green, active_high, sync_raw;

	// Activity counters count edges and saturate at 31; nothing decays them after reset
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pin_prev_q <= 1'b0;
			grn_prev_q <= 1'b0;
			pin_act_q <= 5'h00;
			grn_act_q <= 5'h00;
			hi_cnt_q <= 16'h0000;
			lo_cnt_q <= 16'h0000;
			auto_src_q <= 1'b0;
			auto_pol_q <= 1'b1;
		end else begin
			pin_prev_q <= i_line_sync_pin;
			grn_prev_q <= i_green_embedded_sync;
			if (pin_prev_q != i_line_sync_pin && pin_act_q != 5'h1F) begin
				pin_act_q <= pin_act_q + 5'h01;
			end
			if (grn_prev_q != i_green_embedded_sync && grn_act_q != 5'h1F) begin
				grn_act_q <= grn_act_q + 5'h01;
			end
			// Pin preferred when active; green only when pin is silent
			auto_src_q <= (pin_act_q < 5'(DETECT_CYC)) && (grn_act_q >= 5'(DETECT_CYC));
			if (i_line_sync_pin) begin
				hi_cnt_q <= (hi_cnt_q == 16'hFFFF) ? hi_cnt_q : hi_cnt_q + 16'h0001;
			end else begin
				lo_cnt_q <= (lo_cnt_q == 16'hFFFF) ? lo_cnt_q : lo_cnt_q + 16'h0001;
			end
			if (hi_cnt_q[15] || lo_cnt_q[15]) begin
				// Short level is the pulse: rarely-high means active high
				auto_pol_q <= hi_cnt_q < lo_cnt_q;
				hi_cnt_q <= {1'b0, hi_cnt_q[15:1]};
				lo_cnt_q <= {1'b0, lo_cnt_q[15:1]};
			end
		end
	end

	assign use_green = ctrl_q[CTL_SRC_OVR] ? ctrl_q[CTL_SRC_SEL] : auto_src_q;
	assign active_high = ctrl_q[CTL_POL_OVR] ? ctrl_q[CTL_IN_POL] : auto_pol_q;
	assign sync_raw = use_green ? i_green_embedded_sync : i_line_sync_pin;
	assign o_src_green = use_green;
	assign o_in_active_high = active_high;

	// ****************************************
	// Sync separator width filter
	// ****************************************
	logic [9:0] width_q;
	logic sep_q;
	logic sync_act;
	assign sync_act = active_high ? sync_raw : ~sync_raw;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			width_q <= 10'h000;
			sep_q <= 1'b0;
		end else if (!sync_act) begin
			width_q <= 10'h000;
			sep_q <= 1'b0;
		end else begin
			if (width_q != 10'h3FF) begin
				width_q <= width_q + 10'h001;
			end
			// Pulse passes only once it has lasted threshold x step cycles
			if (width_q + 10'h001 >= 10'(thresh_q * SEP_STEP_CYC)) begin
				sep_q <= 1'b1;
			end
		end
	end
	assign o_sep_sync = sep_q;

	// ****************************************
	// Line sync output pulse
	// ****************************************
	logic [7:0] dur_q;
	logic pulse_q;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			dur_q <= 8'h00;
			pulse_q <= 1'b0;
		end else if (i_fb_clk_en && len_q != 8'h00) begin
			pulse_q <= 1'b1;
			dur_q <= len_q;
		end else if (pulse_q && i_pix_en) begin
			if (dur_q == 8'h01) begin
				pulse_q <= 1'b0;
			end
			dur_q <= dur_q - 8'h01;
		end
	end
	assign o_line_sync = ctrl_q[CTL_OUT_POL] ? pulse_q : ~pulse_q;
endmodule

// ---- vcr_pkg.sv ----
// Shared constants and types for the video capture control register slice
package vcr_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_PHASE = 8'h04;
	localparam logic [7:0] ADDR_GAIN_R = 8'h05;
	localparam logic [7:0] ADDR_GAIN_R_COMMIT = 8'h06;
	localparam logic [7:0] ADDR_GAIN_G = 8'h07;
	localparam logic [7:0] ADDR_GAIN_G_COMMIT = 8'h08;
	localparam logic [7:0] ADDR_GAIN_B = 8'h09;
	localparam logic [7:0] ADDR_GAIN_B_COMMIT = 8'h0A;
	localparam logic [7:0] ADDR_OFS_R_UP = 8'h0B;
	localparam logic [7:0] ADDR_OFS_R_LSB = 8'h0C;
	localparam logic [7:0] ADDR_OFS_G_UP = 8'h0D;
	localparam logic [7:0] ADDR_OFS_G_LSB = 8'h0E;
	localparam logic [7:0] ADDR_OFS_B_UP = 8'h0F;
	localparam logic [7:0] ADDR_OFS_B_LSB = 8'h10;
	localparam logic [7:0] ADDR_SEP_THRESH = 8'h11;
	localparam logic [7:0] ADDR_LSYNC_CTRL = 8'h12;
	localparam logic [7:0] ADDR_LSYNC_LEN = 8'h13;
	localparam logic [7:0] COMMIT_VALUE = 8'h00;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int PHASE_MSB = 7;
	localparam int PHASE_LSB = 3;
	localparam int GAIN_MSB = 6;
	localparam int OFS_LSB_BIT = 7;
	localparam int CTL_SRC_OVR = 7;
	localparam int CTL_SRC_SEL = 6;
	localparam int CTL_POL_OVR = 5;
	localparam int CTL_IN_POL = 4;
	localparam int CTL_OUT_POL = 3;
	localparam logic [4:0] PHASE_RESET = 5'h10;
	localparam logic [6:0] GAIN_RESET = 7'h40;
	localparam logic [8:0] OFS_RESET = 9'h000;
	localparam logic [7:0] SEP_THRESH_RESET = 8'h20;
	localparam logic [7:0] LSYNC_CTRL_RESET = 8'h18;
	localparam logic [7:0] LSYNC_LEN_RESET = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int SEP_STEP_NS = 200;
	localparam int SEP_STEP_CYC = (SEP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DETECT_CYC = 16;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		VCR_IDLE = 2'b00,
		VCR_WRITE = 2'b01,
		VCR_READ = 2'b10
	} vcr_host_state_t;

endpackage

// ---- vcr_if.sv ----
// Register access channel between host controller and capture front end
interface vcr_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;

	modport dev (
		input wr,
		input rd,
		input addr,
		input wdata,
		output rdata,
		output rvalid
	);

	modport host (
		output wr,
		output rd,
		output addr,
		output wdata,
		input rdata,
		input rvalid
	);
endinterface

// ---- vcr_host.sv ----
// Host controller end: issues register writes and reads with commit sequencing
module vcr_host
	import vcr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	vcr_if.host bus,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic o_ready,
	output logic o_done,
	output logic [7:0] o_rdata
);
	// ****************************************
	// Request sequencer
	// ****************************************
	vcr_host_state_t state_q;
	logic [7:0] addr_q, wdata_q, rdata_q;
	logic need_commit_q, done_q;

	// Gain write is followed by a 0x00 commit to the next register
	function automatic logic is_gain(input logic [7:0] a);
		is_gain = (a == ADDR_GAIN_R) || (a == ADDR_GAIN_G) || (a == ADDR_GAIN_B);
	endfunction

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_q <= VCR_IDLE;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			rdata_q <= 8'h00;
			need_commit_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				VCR_IDLE: begin
					if (i_req) begin
						addr_q <= i_addr;
						wdata_q <= i_wdata;
						need_commit_q <= i_we && is_gain(i_addr);
						state_q <= i_we ? VCR_WRITE : VCR_READ;
					end
				end
				VCR_WRITE: begin
					if (need_commit_q) begin
						addr_q <= addr_q + 8'h01;
						wdata_q <= COMMIT_VALUE;
						need_commit_q <= 1'b0;
					end else begin
						done_q <= 1'b1;
						state_q <= VCR_IDLE;
					end
				end
				VCR_READ: begin
					if (bus.rvalid) begin
						rdata_q <= bus.rdata;
						done_q <= 1'b1;
						state_q <= VCR_IDLE;
					end
				end
				default: state_q <= VCR_IDLE;
			endcase
		end
	end

	// Offset upper bytes are committed by the user's own LSB write
	assign bus.wr = (state_q == VCR_WRITE);
	assign bus.rd = (state_q == VCR_READ) && !bus.rvalid;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign o_ready = (state_q == VCR_IDLE);
	assign o_done = done_q;
	assign o_rdata = rdata_q;
endmodule

// ---- vcr_bus_asserts.sv ----
// Protocol checker for the register access channel
module vcr_bus_asserts
	import vcr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] thr_q;
	logic [7:0] ctl_q;

	// Shadow copies, so read data is judged against what was written
	always_ff @(posedge i_clk) begin
		if (!i_rstn) thr_q <= SEP_THRESH_RESET;
		else if (i_wr && i_addr == ADDR_SEP_THRESH) thr_q <= i_wdata;
	end
	always_ff @(posedge i_clk) begin
		if (!i_rstn) ctl_q <= LSYNC_CTRL_RESET;
		else if (i_wr && i_addr == ADDR_LSYNC_CTRL) ctl_q <= i_wdata;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// ****************************************
	// Assertions
	// ****************************************
	read_answer_a: assert property (i_rd |=> i_rvalid)
		else $error("read not answered next cycle");
	answer_single_a: assert property (!i_rd |=> !i_rvalid)
		else $error("answer without read");
	red_commit_a: assert property (i_wr && i_addr == ADDR_GAIN_R |=>
		i_wr && i_addr == ADDR_GAIN_R_COMMIT && i_wdata == COMMIT_VALUE)
		else $error("red gain not committed");
	green_commit_a: assert property (i_wr && i_addr == ADDR_GAIN_G |=>
		i_wr && i_addr == ADDR_GAIN_G_COMMIT && i_wdata == COMMIT_VALUE)
		else $error("green gain not committed");
	blue_commit_a: assert property (i_wr && i_addr == ADDR_GAIN_B |=>
		i_wr && i_addr == ADDR_GAIN_B_COMMIT && i_wdata == COMMIT_VALUE)
		else $error("blue gain not committed");
	zero_read_a: assert property (i_rd && (i_addr == ADDR_GAIN_R_COMMIT || i_addr == 8'h3F)
		|=> i_rdata == 8'h00)
		else $error("commit or unmapped read not zero");
	thresh_read_a: assert property (i_rd && i_addr == ADDR_SEP_THRESH |=>
		i_rdata == $past(thr_q))
		else $error("threshold read wrong");
	ctrl_read_a: assert property (i_rd && i_addr == ADDR_LSYNC_CTRL |=>
		i_rdata == $past(ctl_q))
		else $error("line sync control read wrong");

	read_seen_c: cover property (i_rd ##1 i_rvalid);
	commit_seen_c: cover property (i_wr && i_addr == ADDR_GAIN_G ##1 i_wr);
	thresh_seen_c: cover property (i_wr && i_addr == ADDR_SEP_THRESH);
	offset_seen_c: cover property (i_wr && i_addr == ADDR_OFS_B_LSB);
endmodule

// ---- tb.sv ----
// Testbench joining host and capture front end over the register channel
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("MISMATCH %0t %s", $time, m); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import vcr_pkg::*;
	logic i_clk = 0, i_rstn = 0, i_req = 0, i_we = 0, auto_en = 0, fb = 0, pin = 0, pix = 0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic o_ready, o_done, sep, src_g, act_hi, lsync;
	logic [4:0] phase;
	logic [6:0] gr, gg, gb;
	logic [8:0] ofs_r, tgt_r, ofs_g, ofs_b, tgt_g, tgt_b;
	int num_errors = 0, compares = 0, sep_hi = 0, ls_hi = 0;

	vcr_if vcr_if_i();
	vcr_device vcr_device_i(.i_clk(i_clk), .i_rstn(i_rstn), .bus(vcr_if_i.dev),
		.i_auto_offset_en(auto_en), .i_pix_en(pix), .i_fb_clk_en(fb),
		.i_line_sync_pin(pin), .i_green_embedded_sync(1'b0), .o_phase(phase),
		.o_gain_r(gr), .o_gain_g(gg), .o_gain_b(gb), .o_offset_r(ofs_r),
		.o_offset_g(ofs_g), .o_offset_b(ofs_b), .o_clamp_target_r(tgt_r),
		.o_clamp_target_g(tgt_g), .o_clamp_target_b(tgt_b), .o_sep_sync(sep), .o_src_green(src_g),
		.o_in_active_high(act_hi), .o_line_sync(lsync));
	vcr_host vcr_host_i(.i_clk(i_clk), .i_rstn(i_rstn), .bus(vcr_if_i.host),
		.i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata),
		.o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata));
	vcr_bus_asserts vcr_bus_asserts_i(.i_clk(i_clk), .i_rstn(i_rstn), .i_wr(vcr_if_i.wr),
		.i_rd(vcr_if_i.rd), .i_addr(vcr_if_i.addr), .i_wdata(vcr_if_i.wdata),
		.i_rdata(vcr_if_i.rdata), .i_rvalid(vcr_if_i.rvalid));

	always #50 i_clk = ~i_clk;
	// Pixel enable every second cycle, so the pulse length is counted in pixels
	always @(posedge i_clk) begin
		pix <= ~pix;
		if (sep === 1'b1) sep_hi++;
		if (lsync === 1'b1 && pix === 1'b1) ls_hi++;
	end

	task automatic conclude();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// One host transaction; waits for completion under a bound
	task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		while (o_ready !== 1'b1 && n < 20) begin @(posedge i_clk); n++; end
		i_req <= 1'b1; i_we <= we; i_addr <= a; i_wdata <= d;
		@(posedge i_clk);
		i_req <= 1'b0;
		do begin @(posedge i_clk); #1; n++; end while (o_done !== 1'b1 && n < 40);
		if (n >= 40) `CHK(1'b0, 1'b1, "no completion")
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		`CHK(o_rdata, e, "read data")
	endtask

	task automatic pulse(input int n);
		@(posedge i_clk) pin <= 1'b1;
		repeat (n) @(posedge i_clk);
		pin <= 1'b0;
		repeat (6) @(posedge i_clk);
	endtask

	initial begin
		repeat (5000) @(posedge i_clk);
		num_errors++;
		conclude();
	end

	initial begin
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1;
		`CHK(phase, 5'h10, "phase reset")
		`CHK(gr, 7'h40, "gain reset")
		`CHK(lsync, 1'b0, "idle line sync")
		`CHK({src_g, act_hi}, 2'b01, "auto source and polarity")
		rdchk(ADDR_SEP_THRESH, 8'h20);
		rdchk(ADDR_LSYNC_CTRL, 8'h18);
		acc(1'b1, ADDR_PHASE, 8'hF8);
		`CHK(phase, 5'h1F, "phase max")
		for (int i = 0; i < 3; i++) acc(1'b1, ADDR_GAIN_R + 8'(2 * i), 8'h7F);
		`CHK({gr, gg, gb}, {3{7'h7F}}, "gains")
		acc(1'b1, ADDR_GAIN_G, 8'h00);
		`CHK(gg, 7'h00, "green min")
		rdchk(ADDR_GAIN_R_COMMIT, 8'h00);
		rdchk(8'h3F, 8'h00);
		acc(1'b1, ADDR_OFS_R_UP, 8'hFF);
		`CHK(tgt_r, 9'h000, "offset pending")
		acc(1'b1, ADDR_OFS_R_LSB, 8'h80);
		`CHK(tgt_r, 9'h1FF, "offset nine bits")
		`CHK(ofs_r, 9'h17F, "manual offset")
		@(posedge i_clk) auto_en <= 1'b1;
		@(posedge i_clk) #1;
		`CHK(ofs_r, 9'h1FF, "auto offset")
		acc(1'b1, ADDR_OFS_G_UP, 8'h12);
		acc(1'b1, ADDR_OFS_G_LSB, 8'h00);
		acc(1'b1, ADDR_OFS_B_UP, 8'h01);
		acc(1'b1, ADDR_OFS_B_LSB, 8'h80);
		`CHK({tgt_g, tgt_b, tgt_r}, {9'h024, 9'h003, 9'h1FF}, "green blue offsets")
		`CHK({ofs_g, ofs_b}, {9'h024, 9'h003}, "auto green blue")
		acc(1'b1, ADDR_LSYNC_LEN, 8'h03);
		ls_hi = 0;
		@(posedge i_clk) fb <= 1'b1;
		@(posedge i_clk) fb <= 1'b0;
		repeat (10) @(posedge i_clk);
		`CHK(ls_hi, 3, "pulse length")
		acc(1'b1, ADDR_LSYNC_CTRL, 8'hB0);
		`CHK({lsync, src_g, act_hi}, 3'b101, "low output, pin, high")
		acc(1'b1, ADDR_LSYNC_CTRL, 8'hE8);
		`CHK({src_g, act_hi}, 2'b10, "green, low")
		acc(1'b1, ADDR_LSYNC_CTRL, 8'hB8);
		acc(1'b1, ADDR_SEP_THRESH, 8'h02);
		sep_hi = 0;
		pulse(2);
		`CHK(sep_hi, 0, "short pulse")
		pulse(8);
		`CHK(sep_hi > 0, 1'b1, "long pulse")
		conclude();
	end
endmodule
